/* rtl/bit_timer.sv */
// Purpose: 8-bit up-counting interval timer with AXI4-Lite register access
// Assumes: CLOCK_I is the instruction clock; RTC_CLK_I is an unrelated 32768 Hz clock
// Notes:   Registers MODE 0x0, COUNT 0x4, STATUS 0x8; other addresses answer SLVERR
//
// Notes on behaviour
// - Count held while run enable is 0, counting starts once it is 1.
// - Eight-bit counter, 256 steps, one increment per selected timer clock.
// - Overflow only on the wrap from 0xFF to 0x00.
// - Overflow sets the request flag; only software clears it.
// - No reload: after overflow counting continues from zero.
// - Flag with interrupt enable requests the interrupt at vector address 8.
// - Counting is identical in normal, slow and green power modes.
// - In green mode an overflow also wakes the system.
// - Prescale select 000b gives /256 halving each step to /2 at 111b.
// - RTC select counts the 32 kHz source, only with the RTC clock option.
// - RTC input is 32768 Hz over 64, full 256 counts, 0.5 s period.
// - Mode register: run bit 7, prescale bits 6..4, RTC bit 0, reset 0.
// - Prescale select has no effect in RTC mode.
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module bit_timer (
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        NRST_I,
    // AXI4-Lite write address
    input  wire logic [3:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    // AXI4-Lite write data
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    // AXI4-Lite write response
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    // AXI4-Lite read address
    input  wire logic [3:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    // AXI4-Lite read data
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    // System side
    input  wire logic        RTC_CLK_I,
    input  wire logic        RTC_OPTION_I,
    input  wire logic        GREEN_MODE_I,
    output logic             IRQ_REQ_O,
    output logic [7:0]       IRQ_VECTOR_O,
    output logic             WAKE_O
);

    // Register state
    bit_pkg::bit_mode_s mode;
    logic [7:0]         tick_counter_value;
    logic               overflow_request_flag;
    logic               overflow_irq_enable;
    logic               rtc_option;

    // Bus state
    logic               aw_held;
    logic               w_held;
    logic [3:0]         aw_addr;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;

    // RTC edge path
    logic               rtc_sync;
    logic               rtc_last;
    logic               rtc_edge;
    logic               tick;

    // Decode wires
    logic               aw_take;
    logic               w_take;
    logic               wr_fire;
    logic               wr_low;
    logic               wr_mode;
    logic               wr_count;
    logic               wr_status;
    logic               wr_ok;
    logic               ar_take;
    logic               rd_ok;
    logic [31:0]        rd_word;
    logic               overflow;
    logic               rtc_mode;
    logic [7:0]         next_count;
    logic               next_flag;
    logic [3:0]         next_aw_addr;
    logic [31:0]        next_w_data;
    logic [3:0]         next_w_strb;

    function automatic logic addr_mapped(input logic [3:0] a);
        addr_mapped = (a == bit_pkg::ADDR_MODE) || (a == bit_pkg::ADDR_COUNT) || (a == bit_pkg::ADDR_STATUS);
    endfunction : addr_mapped

    // Write channel: address and data taken in either order, response after both
    assign aw_take      = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
    assign w_take       = S_AXI_WVALID_I & S_AXI_WREADY_O;
    assign S_AXI_AWREADY_O = ~aw_held & ~bvalid;
    assign S_AXI_WREADY_O  = ~w_held & ~bvalid;
    assign next_aw_addr = aw_take ? S_AXI_AWADDR_I : aw_addr;
    assign next_w_data  = w_take ? S_AXI_WDATA_I : w_data;
    assign next_w_strb  = w_take ? S_AXI_WSTRB_I : w_strb;
    assign wr_fire      = (aw_held | aw_take) & (w_held | w_take) & ~bvalid;
    // All fields live in byte lane 0; a write without it stores nothing
    assign wr_low       = wr_fire & next_w_strb[0];
    assign wr_ok        = addr_mapped(next_aw_addr);
    assign wr_mode      = wr_low & (next_aw_addr == bit_pkg::ADDR_MODE);
    assign wr_count     = wr_low & (next_aw_addr == bit_pkg::ADDR_COUNT);
    assign wr_status    = wr_low & (next_aw_addr == bit_pkg::ADDR_STATUS);

    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= bit_pkg::RESP_OKAY;
        end
        else
        begin
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            aw_held <= wr_fire ? 1'b0 : (aw_held | aw_take);
            w_held  <= wr_fire ? 1'b0 : (w_held | w_take);
            if (wr_fire)
            begin
                bvalid <= 1'b1;
                bresp  <= wr_ok ? bit_pkg::RESP_OKAY : bit_pkg::RESP_SLVERR;
            end
            else if (S_AXI_BREADY_I)
                bvalid <= 1'b0;
        end
    end

    assign S_AXI_BVALID_O = bvalid;
    assign S_AXI_BRESP_O  = bresp;

    // Read channel: one read at a time, data registered
    assign ar_take = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
    assign S_AXI_ARREADY_O = ~rvalid;
    assign rd_ok   = addr_mapped(S_AXI_ARADDR_I);
    assign rd_word = (S_AXI_ARADDR_I == bit_pkg::ADDR_MODE)   ?
                         {24'h0, mode.run, mode.prescale, 3'h0, mode.rtc} :
                     (S_AXI_ARADDR_I == bit_pkg::ADDR_COUNT)  ? {24'h0, tick_counter_value} :
                     (S_AXI_ARADDR_I == bit_pkg::ADDR_STATUS) ?
                         {28'h0, rtc_mode, GREEN_MODE_I, overflow_irq_enable, overflow_request_flag} :
                     32'h0;

    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= bit_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_ok ? bit_pkg::RESP_OKAY : bit_pkg::RESP_SLVERR;
        end
        else if (S_AXI_RREADY_I)
            rvalid <= 1'b0;
    end

    assign S_AXI_RVALID_O = rvalid;
    assign S_AXI_RDATA_O  = rdata;
    assign S_AXI_RRESP_O  = rresp;

    // Slow clock crosses in as a level, edge found after the synchroniser
    bit_sync #(
        .WIDTH (1)
    ) u_rtc_sync (
        .clk_i   (CLOCK_I),
        .nrst_i  (NRST_I),
        .async_i (RTC_CLK_I),
        .sync_o  (rtc_sync)
    );

    // Option strap is a pin too; two flops keep a slow ramp from going metastable
    bit_sync #(
        .WIDTH (1)
    ) u_opt_sync (
        .clk_i   (CLOCK_I),
        .nrst_i  (NRST_I),
        .async_i (RTC_OPTION_I),
        .sync_o  (rtc_option)
    );

    assign rtc_edge = rtc_sync & ~rtc_last;
    // RTC select is ignored unless the RTC clock option is fitted
    assign rtc_mode = mode.rtc & rtc_option;

    bit_prescale u_prescale (
        .clk_i      (CLOCK_I),
        .nrst_i     (NRST_I),
        .run_i      (mode.run),
        .prescale_i (mode.prescale),
        .rtc_mode_i (rtc_mode),
        .rtc_edge_i (rtc_edge),
        .tick_o     (tick)
    );

    // Power mode never gates the tick, so counting is the same in every mode
    assign overflow   = tick & (tick_counter_value == bit_pkg::CNT_FULL);
    // Software write wins over a tick in the same cycle
    assign next_count = wr_count ? next_w_data[bit_pkg::CNT_W-1:0] :
                        tick     ? tick_counter_value + 8'h01 :
                                   tick_counter_value;
    // Hardware set wins over a software clear in the same cycle
    assign next_flag  = overflow | (wr_status ? (overflow_request_flag & next_w_data[bit_pkg::STAT_FLAG_BIT])
                                              : overflow_request_flag);

    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            mode                  <= bit_pkg::MODE_RESET;
            tick_counter_value    <= bit_pkg::CNT_RESET;
            overflow_request_flag <= 1'b0;
            overflow_irq_enable   <= 1'b0;
            rtc_last              <= 1'b0;
            WAKE_O                <= 1'b0;
        end
        else
        begin
            rtc_last           <= rtc_sync;
            tick_counter_value <= next_count;
            overflow_request_flag <= next_flag;
            WAKE_O             <= overflow & GREEN_MODE_I;
            if (wr_mode)
            begin
                mode.run      <= next_w_data[bit_pkg::MODE_RUN_BIT];
                mode.prescale <= next_w_data[bit_pkg::MODE_PRE_HI:bit_pkg::MODE_PRE_LO];
                mode.rtc      <= next_w_data[bit_pkg::MODE_RTC_BIT];
            end
            if (wr_status)
                overflow_irq_enable <= next_w_data[bit_pkg::STAT_IEN_BIT];
        end
    end

    // Request holds until software clears the flag or the interrupt enable inside the service routine
    assign IRQ_REQ_O    = overflow_request_flag & overflow_irq_enable;
    assign IRQ_VECTOR_O = bit_pkg::IRQ_VECTOR;

    // Checks
    a_hold_when_off: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (!mode.run && !wr_count) |=> $stable(tick_counter_value))
        else $error("Counter moved while stopped");

    a_count_step: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (tick && !wr_count) |=> (tick_counter_value == 8'($past(tick_counter_value) + 8'h01)))
        else $error("Counter did not step by one");

    a_wrap_overflow: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        overflow |=> (tick_counter_value == bit_pkg::CNT_ZERO || $past(wr_count)))
        else $error("Overflow without wrap to zero");

    a_flag_set: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        overflow |=> overflow_request_flag)
        else $error("Overflow did not set flag");

    a_flag_sticky: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (overflow_request_flag && !wr_status) |=> overflow_request_flag)
        else $error("Flag cleared without software write");

    a_irq_vector: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (overflow && overflow_irq_enable && !wr_status) |=> IRQ_REQ_O && (IRQ_VECTOR_O == bit_pkg::IRQ_VECTOR))
        else $error("Interrupt request or vector wrong");

    a_green_wake: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (overflow && GREEN_MODE_I) |=> WAKE_O ##1 !WAKE_O || $past(overflow))
        else $error("Green mode overflow gave no wake pulse");

    a_no_stray_wake: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        WAKE_O |-> $past(overflow) && $past(GREEN_MODE_I))
        else $error("Wake without overflow");

    a_write_loads: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        wr_count |=> tick_counter_value == $past(next_w_data[7:0]))
        else $error("Counter write not taken at once");

    a_rtc_gate: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (rtc_mode && tick) |-> rtc_sync && !$past(rtc_sync))
        else $error("RTC tick without slow clock edge");

    a_bresp_after: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        $rose(bvalid) |-> $past(aw_held || aw_take) && $past(w_held || w_take))
        else $error("Write response before address and data");

    a_stop_no_tick: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        !mode.run |-> !tick)
        else $error("Timer tick while stopped");

    a_fcpu_spacing: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (!rtc_mode && tick) |=> (!tick || rtc_mode))
        else $error("Divided clock ticked twice in a row");

    a_no_false_flag: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (!overflow_request_flag && !overflow) |=> !overflow_request_flag)
        else $error("Flag set without overflow");

    a_flag_sw_clear: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (wr_status && !next_w_data[bit_pkg::STAT_FLAG_BIT] && !overflow) |=> !overflow_request_flag)
        else $error("Software clear of flag ignored");

    a_wake_only_green: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (overflow && !GREEN_MODE_I) |=> !WAKE_O)
        else $error("Wake outside green mode");

    a_wake_single: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        WAKE_O |=> !WAKE_O)
        else $error("Wake pulse longer than one cycle");

    a_mode_write: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        wr_mode |=> (mode.run == $past(next_w_data[bit_pkg::MODE_RUN_BIT]))
                 && (mode.rtc == $past(next_w_data[bit_pkg::MODE_RTC_BIT])))
        else $error("Mode write not stored");

    a_read_answer: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        ar_take |=> S_AXI_RVALID_O)
        else $error("Read address taken without answer");

    a_write_refuse: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        S_AXI_BVALID_O |-> (!S_AXI_AWREADY_O && !S_AXI_WREADY_O))
        else $error("Write taken while response pending");

    a_read_refuse: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("Read taken while data pending");

endmodule : bit_timer

/* rtl/bit_pkg.sv */
// Purpose: Shared constants and types for the 8-bit interval timer
// Assumes: 32-bit AXI4-Lite register bus, CLOCK_I is the instruction clock
// Notes:   Every offset and field position, and the mode and counter reset values, used by the RTL live here
package bit_pkg;

    // Register byte addresses
    localparam logic [3:0] ADDR_MODE   = 4'h0;
    localparam logic [3:0] ADDR_COUNT  = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam int         ADDR_W      = 4;

    // Mode register field positions
    localparam int MODE_RUN_BIT   = 7;
    localparam int MODE_PRE_HI    = 6;
    localparam int MODE_PRE_LO    = 4;
    localparam int MODE_RTC_BIT   = 0;

    // Status register field positions
    localparam int STAT_FLAG_BIT  = 0;
    localparam int STAT_IEN_BIT   = 1;
    localparam int STAT_GREEN_BIT = 2;
    localparam int STAT_RTC_BIT   = 3;

    // Counter geometry
    localparam int          CNT_W      = 8;
    localparam logic [7:0]  CNT_FULL   = 8'hFF;
    localparam logic [7:0]  CNT_ZERO   = 8'h00;
    localparam logic [7:0]  CNT_RESET  = 8'h00;

    // Prescaler: largest divisor minus one, shifted right by the select code
    localparam logic [7:0]  PRE_MAX    = 8'hFF;
    localparam logic [7:0]  RTC_DIV    = 8'h40;
    localparam logic [7:0]  RTC_LIMIT  = RTC_DIV - 8'h01;

    // Interrupt vector program address
    localparam logic [7:0]  IRQ_VECTOR = 8'h08;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Timer mode register contents
    typedef struct packed {
        logic       run;
        logic [2:0] prescale;
        logic       rtc;
    } bit_mode_s;

    localparam bit_mode_s MODE_RESET = '{run: 1'b0, prescale: 3'h0, rtc: 1'b0};

endpackage : bit_pkg

/* rtl/bit_sync.sv */
// Purpose: Two-flop synchroniser for a level from another clock
// Assumes: Input is a slow level or clock, far below CLOCK_I
// Notes:   Stage one feeds only stage two
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            stage1 <= '0;
            sync_o <= '0;
        end
        else
        begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule : bit_sync

/* rtl/bit_prescale.sv */
// Purpose: Timer clock tick from instruction clock or from 32768 Hz edges
// Assumes: rtc_edge_i is a one-cycle pulse per rising edge of the slow clock
// Notes:   The divider is cleared while the timer is stopped
`timescale 1ns/1ps
module bit_prescale (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [2:0] prescale_i,
    input  wire logic       rtc_mode_i,
    input  wire logic       rtc_edge_i,
    // Tick out
    output logic            tick_o
);

    logic [7:0] div_cnt;
    logic [7:0] limit;
    logic       step;
    logic       at_limit;
    logic [7:0] next_div_cnt;

    // Select code only matters outside RTC mode
    assign limit        = rtc_mode_i ? bit_pkg::RTC_LIMIT : (bit_pkg::PRE_MAX >> prescale_i);
    assign step         = rtc_mode_i ? rtc_edge_i : 1'b1;
    // Compare with >= so a mode change never strands the divider above its limit
    assign at_limit     = (div_cnt >= limit);
    assign tick_o       = run_i & step & at_limit;
    assign next_div_cnt = !run_i ? 8'h00 : (step ? (at_limit ? 8'h00 : div_cnt + 8'h01) : div_cnt);

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            div_cnt <= 8'h00;
        else
            div_cnt <= next_div_cnt;
    end

endmodule : bit_prescale

/* testbench/tb.sv */
// Purpose: Self-checking bench for the 8-bit interval timer over AXI4-Lite
// Assumes: RTC clock sped up to 80 ns period so a tick fits the run
// Notes:   Counter is only read while stopped, so the model knows its value
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] RUN = 32'h00000080;
    logic        clk;
    logic        nrst;
    logic [3:0]  awaddr;
    logic [3:0]  araddr;
    logic [3:0]  wstrb;
    logic [31:0] wdata;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        rtc_clk, rtc_opt, green;
    logic        awready, wready, bvalid, arready, rvalid, irq, wake;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  vec;
    logic [7:0]  seed;
    int          err_total, tests_run, cycles, wakes, n;
    logic [31:0] m_mode, m_cnt, m_flag, m_ien;

    bit_timer DUT (
        .CLOCK_I(clk), .NRST_I(nrst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .RTC_CLK_I(rtc_clk), .RTC_OPTION_I(rtc_opt), .GREEN_MODE_I(green),
        .IRQ_REQ_O(irq), .IRQ_VECTOR_O(vec), .WAKE_O(wake)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Unrelated phase to the instruction clock
    initial
    begin
        rtc_clk = 1'b0;
        #3;
        forever #40 rtc_clk = ~rtc_clk;
    end

    always @(negedge clk) if (wake === 1'b1) wakes++;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            final_report();
        end
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic a_hs, w_hs, a_dn, w_dn, got;
        logic [1:0] r;
        a_dn = 1'b0;
        w_dn = 1'b0;
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(negedge clk);
            a_hs = awvalid & awready;
            w_hs = wvalid & wready;
            @(posedge clk);
            if (a_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            a_dn = a_dn | a_hs;
            w_dn = w_dn | w_hs;
        end while (!(a_dn && w_dn));
        do
        begin
            @(negedge clk);
            got = bvalid;
            r = bresp;
            @(posedge clk);
        end while (got !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hs, got;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(negedge clk);
            hs = arvalid & arready;
            @(posedge clk);
        end while (hs !== 1'b1);
        arvalid <= 1'b0;
        do
        begin
            @(negedge clk);
            got = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
        end while (got !== 1'b1);
        rready <= 1'b0;
    endtask : axi_rd

    // Write through the bus and mirror the effect in the model
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ok;
        ok = (a == 4'h0) || (a == 4'h4) || (a == 4'h8);
        axi_wr(a, d, 4'hF, ok ? 2'h0 : 2'h2);
        if (a == 4'h0) m_mode = d & 32'h000000F1;
        if (a == 4'h4) m_cnt = d & 32'h000000FF;
        if (a == 4'h8) m_ien = {31'h0, d[1]};
        if ((a == 4'h8) && !d[0]) m_flag = 32'h0;
    endtask : wr

    task automatic rd_chk(input logic [3:0] a);
        logic [31:0] d, e;
        logic [1:0] r;
        axi_rd(a, d, r);
        case (a)
            4'h0: e = m_mode;
            4'h4: e = m_cnt;
            4'h8: e = {28'h0, m_mode[0] & rtc_opt, green, m_ien[0], m_flag[0]};
            default: e = 32'h0;
        endcase
        chk("rdata", e, d);
        chk("rresp", (a == 4'h0 || a == 4'h4 || a == 4'h8) ? 32'h0 : 32'h2, {30'h0, r});
    endtask : rd_chk

    // Cycles from the starting write to the interrupt request
    task automatic measure(input int lo, input int hi);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (irq !== 1'b1 && n < 2000);
        m_flag = 32'h1;
        tests_run++;
        if (n < lo || n > hi)
        begin
            err_total++;
            $display("[ERR] overflow delay expected %0d..%0d seen %0d", lo, hi, n);
        end
        chk("vector", 32'h8, {24'h0, vec});
    endtask : measure

    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        nrst = 1'b0; awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0; wdata = 32'h0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        rtc_opt = 1'b0; green = 1'b0; seed = 8'h34;
        m_mode = 0; m_cnt = 0; m_flag = 0; m_ien = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(4'h0);
        rd_chk(4'h4);
        rd_chk(4'h8);
        rd_chk(4'hC);
        wr(4'hC, 32'hFF);
        axi_wr(4'h4, 32'h5A, 4'h0, 2'h0);
        rd_chk(4'h4);
        // Stopped timer must keep any loaded value
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr_next(seed);
            wr(4'h0, {24'h0, seed & 8'h71});
            wr(4'h4, {24'h0, seed});
            repeat (200) @(posedge clk);
            rd_chk(4'h0);
            rd_chk(4'h4);
        end
        // Every prescale code, two ticks from 0xFE; RTC bit ignored without the option
        for (int p = 0; p < 8; p++)
        begin
            green <= (p == 7);
            wr(4'h0, 32'h0);
            wr(4'h4, 32'hFE);
            wr(4'h8, 32'h2);
            wr(4'h0, RUN | (p << 4) | (p == 3));
            measure(2 * (256 >> p) - 1, 2 * (256 >> p) + 2);
            if (p == 0)
            begin
                wr(4'h0, 32'h0);
                m_cnt = 32'h0;
                rd_chk(4'h4);
                rd_chk(4'h8);
                wr(4'h8, 32'h3);
                rd_chk(4'h8);
            end
        end
        wr(4'h0, 32'h0);
        rd_chk(4'h8);
        green <= 1'b0;
        chk("wake pulses", 32'h1, wakes);
        wr(4'h8, 32'h2);
        wr(4'h4, 32'h10);
        wr(4'h0, RUN | 32'h70);
        wr(4'h4, 32'hFE);
        measure(2, 6);
        wr(4'h0, 32'h0);
        rtc_opt <= 1'b1;
        wr(4'h8, 32'h2);
        wr(4'h4, 32'hFF);
        wr(4'h0, RUN | 32'h71);
        measure(505, 525);
        rd_chk(4'h8);
        wr(4'h0, 32'h0);
        wr(4'h8, 32'h2);
        @(negedge clk);
        chk("irq after clear", 32'h0, {31'h0, irq});
        final_report();
    end
endmodule : tb
